/* pbr_cfg.svh */
// offsets, field positions, reset values and timing counts of the basic registers
`ifndef PBR_CFG_SVH
`define PBR_CFG_SVH
`define PBR_REG_CTL   5'h00
`define PBR_REG_STS   5'h01
`define PBR_CTL_RST   15
`define PBR_CTL_LPBK  14
`define PBR_CTL_SPD0  13
`define PBR_CTL_ANEN  12
`define PBR_CTL_PWD   11
`define PBR_CTL_ISO   10
`define PBR_CTL_RSAN  9
`define PBR_CTL_DUP   8
`define PBR_CTL_COLT  7
`define PBR_CTL_SPD1  6
`define PBR_CTL_DEF   16'h3100
`define PBR_CTL_WMASK 16'hFFC0
`define PBR_STS_FIXED 16'h7949
`define PBR_STS_ANC   5
`define PBR_STS_RF    4
`define PBR_STS_LINK  2
`define PBR_OP_RD     2'h2
`define PBR_OP_WR     2'h1
`define PBR_HDR_LAST  5'h0C
`define PBR_TA_LAST   5'h01
`define PBR_DAT_LAST  5'h0F
`define PBR_SRST_NS   100000
`define PBR_CLK_NS    5
`define PBR_SRST_CYC  (`PBR_SRST_NS / `PBR_CLK_NS)
`endif

/* pbr_mdio_eng.sv */
// serial management frame engine, runs on the management clock
`include "pbr_cfg.svh"
module pbr_mdio_eng
   import pbr_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h00
) (
   input  wire logic        mdc,
   input  wire logic        resetn,
   input  wire logic        mdio_in,
   output logic             mdio_out,
   output logic             mdio_oe,
   output logic             rd_tgl,
   output logic             wr_tgl,
   output logic [4:0]       reg_addr,
   output pbr_word_t        wr_data,
   input  wire pbr_word_t   rd_data
);
   pbr_mdio_st_t st;
   logic [4:0]   cnt;
   pbr_word_t    sr;
   pbr_word_t    rsh;
   logic         last_one;
   logic         is_rd;
   logic         hit;
   logic [12:0]  hdr;

   assign hdr = {sr[11:0], mdio_in};

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mdc or negedge resetn) begin
      if (!resetn) begin
         st       <= PBR_IDLE;
         cnt      <= 5'h00;
         sr       <= 16'h0000;
         last_one <= 1'b0;
         is_rd    <= 1'b0;
         hit      <= 1'b0;
         rd_tgl   <= 1'b0;
         wr_tgl   <= 1'b0;
         reg_addr <= 5'h00;
         wr_data  <= 16'h0000;
      end else begin
         last_one <= mdio_in;
         case (st)
            PBR_IDLE: begin
               // no preamble needed, one idle bit before start
               if (last_one && !mdio_in) begin // RULE15 RULE17
                  st  <= PBR_HDR;
                  cnt <= 5'h00;
               end
            end
            PBR_HDR: begin
               sr  <= {sr[14:0], mdio_in};
               cnt <= cnt + 5'h01;
               if (cnt == `PBR_HDR_LAST) begin
                  st    <= PBR_TA;
                  cnt   <= 5'h00;
                  is_rd <= hdr[11:10] == `PBR_OP_RD;
                  hit   <= hdr[12] && hdr[9:5] == PHY_ADDR &&
                           (hdr[11:10] == `PBR_OP_RD || hdr[11:10] == `PBR_OP_WR);
                  reg_addr <= hdr[4:0];
                  if (hdr[12] && hdr[9:5] == PHY_ADDR && hdr[11:10] == `PBR_OP_RD) begin
                     rd_tgl <= ~rd_tgl;
                  end
               end
            end
            PBR_TA: begin
               cnt <= cnt + 5'h01;
               if (cnt == `PBR_TA_LAST) begin
                  st  <= PBR_DAT;
                  cnt <= 5'h00;
               end
            end
            PBR_DAT: begin
               sr  <= {sr[14:0], mdio_in};
               cnt <= cnt + 5'h01;
               if (cnt == `PBR_DAT_LAST) begin
                  st <= PBR_IDLE;
                  if (hit && !is_rd) begin
                     wr_data <= {sr[14:0], mdio_in};
                     wr_tgl  <= ~wr_tgl;
                  end
               end
            end
            default: st <= PBR_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read word is loaded by the far side during the turnaround and taken on the second turnaround bit
   always_ff @(posedge mdc or negedge resetn) begin
      if (!resetn) begin
         mdio_out <= 1'b1;
         mdio_oe  <= 1'b0;
         rsh      <= 16'h0000;
      end else if (st == PBR_TA && hit && is_rd) begin
         if (cnt == 5'h00) begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
         end else begin
            mdio_out <= rd_data[15];
            rsh      <= {rd_data[14:0], 1'b0};
         end
      end else if (st == PBR_DAT && mdio_oe) begin
         mdio_out <= rsh[15];
         rsh      <= {rsh[14:0], 1'b0};
         if (cnt == `PBR_DAT_LAST) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b1;
         end
      end
   end
endmodule // pbr_mdio_eng

/* pbr_pkg.sv */
// types shared by the basic register block
package pbr_pkg;
   typedef enum logic [1:0] {
      PBR_IDLE,
      PBR_HDR,
      PBR_TA,
      PBR_DAT
   } pbr_mdio_st_t;
   typedef logic [15:0] pbr_word_t;
endpackage

/* pbr_regs.sv */
// basic mode control and status registers behind the management port
`include "pbr_cfg.svh"
//
// Overview of operation
// RULE1 - control bit 15 resets core, self clears
// RULE2 - reset end restores control and status defaults
// RULE3 - control bit 14 enables internal loopback
// RULE4 - bits 6 and 13 select speed
// RULE5 - negotiation done updates bit 13 speed
// RULE6 - bit 12 negotiation, bit 8 duplex forced
// RULE7 - negotiation done updates bit 8 duplex
// RULE8 - bit 11 powers down, link down
// RULE9 - bit 10 isolates transmit and receive pins
// RULE10 - bit 9 restarts negotiation, self clears
// RULE11 - bit 7 enables collision test
// RULE12 - status capability bits fixed, bit 15 zero
// RULE13 - status bit 8 reads one
// RULE14 - status bit 7 reads zero
// RULE15 - bit 6 one, suppressed preamble accepted
// RULE16 - host sends 32 preamble bits first
// RULE17 - host leaves one idle bit between frames
// RULE18 - status bit 5 shows negotiation complete
// RULE19 - remote fault sticky, cleared by read, reset
// RULE20 - link status latches low until read
// RULE21 - reserved bits read zero, writes ignored
module pbr_regs
   import pbr_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR    = 5'h00,
   parameter int         SRST_CYCLES = `PBR_SRST_CYC
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe,
   input  wire logic       autoneg_complete,
   input  wire logic       an_speed100,
   input  wire logic       an_full,
   input  wire logic       remote_fault_in,
   input  wire logic       link_up_in,
   input  wire logic [3:0] tx_data_in,
   input  wire logic       transmit_control_input,
   output logic [3:0]      tx_data_core,
   output logic            tx_ctl_core,
   input  wire logic       rx_clk_in,
   input  wire logic       rx_ctl_in,
   input  wire logic [3:0] rx_data_in,
   output logic            receive_clock_output,
   output logic            receive_control_output,
   output logic [3:0]      rx_data_out,
   output logic            rx_oe,
   output logic            core_reset,
   output logic            loopback_en,
   output logic            speed_100,
   output logic            full_duplex,
   output logic            autoneg_enable,
   output logic            autoneg_restart,
   output logic            power_down_bit,
   output logic            isolate,
   output logic            collision_test
);
   if (SRST_CYCLES < 1 || SRST_CYCLES > 32767) begin : g_bad_srst
      $error("SRST_CYCLES out of range");
   end

   localparam logic [14:0] SRST_LOAD = 15'(SRST_CYCLES - 1);

   pbr_word_t   ctl;
   pbr_word_t   sts;
   pbr_word_t   rd_data;
   pbr_word_t   eng_wr_data;
   logic [4:0]  eng_addr;
   logic        eng_rd_tgl;
   logic        eng_wr_tgl;
   logic [1:0]  tg_s1;
   logic [1:0]  tg_s2;
   logic [1:0]  tg_s3;
   logic [1:0]  tg_seen;
   logic [1:0]  tg_ev;
   logic        rd_ev;
   logic        wr_ev;
   logic [1:0]  wr_sel;
   logic [1:0]  rd_sel;
   logic [14:0] srst_cnt;
   logic        srst_done;
   logic        rf;
   logic        link_ll;
   logic        link_view;
   logic        an_prev;
   logic        an_rise;

   // one-hot select of the two implemented registers
   function automatic logic [1:0] reg_sel(input logic [4:0] a);
      reg_sel = {a == `PBR_REG_STS, a == `PBR_REG_CTL};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   pbr_mdio_eng #(
      .PHY_ADDR (PHY_ADDR)
   ) u_eng (
      .mdc      (mdc),
      .resetn   (resetn),
      .mdio_in  (mdio_in),
      .mdio_out (mdio_out),
      .mdio_oe  (mdio_oe),
      .rd_tgl   (eng_rd_tgl),
      .wr_tgl   (eng_wr_tgl),
      .reg_addr (eng_addr),
      .wr_data  (eng_wr_data),
      .rd_data  (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // request toggles cross here; address and data are quiet by then
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tg_s1   <= 2'h0;
         tg_s2   <= 2'h0;
         tg_s3   <= 2'h0;
         tg_seen <= 2'h0;
      end else begin
         tg_s1   <= {eng_wr_tgl, eng_rd_tgl};
         tg_s2   <= tg_s1;
         tg_s3   <= tg_s2;
         tg_seen <= tg_seen ^ tg_ev;
      end
   end

   assign tg_ev  = ~(tg_s2 ^ tg_s3) & (tg_s3 ^ tg_seen);
   assign rd_ev  = tg_ev[0];
   assign wr_ev  = tg_ev[1];
   assign wr_sel = reg_sel(eng_addr);
   assign rd_sel = reg_sel(eng_addr);

   ////////////////////////////////////////////////////////////////////////////////
   assign srst_done = ctl[`PBR_CTL_RST] && srst_cnt == 15'h0000;
   assign an_rise   = autoneg_complete && !an_prev;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         srst_cnt <= 15'h0000;
      end else if (wr_ev && wr_sel[0] && eng_wr_data[`PBR_CTL_RST] && !ctl[`PBR_CTL_RST]) begin
         srst_cnt <= SRST_LOAD; // RULE1
      end else if (srst_cnt != 15'h0000) begin
         srst_cnt <= srst_cnt - 15'h0001;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         an_prev <= 1'b0;
      end else begin
         an_prev <= autoneg_complete;
      end
   end

   // writes are dropped while the software reset runs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl <= `PBR_CTL_DEF;
      end else if (srst_done) begin
         ctl <= `PBR_CTL_DEF; // RULE1 RULE2
      end else begin
         if (wr_ev && wr_sel[0] && !ctl[`PBR_CTL_RST]) begin
            ctl <= eng_wr_data & `PBR_CTL_WMASK; // RULE3 RULE4 RULE6 RULE8 RULE11 RULE21
         end else if (ctl[`PBR_CTL_RSAN]) begin
            ctl[`PBR_CTL_RSAN] <= 1'b0; // RULE10
         end
         if (an_rise && ctl[`PBR_CTL_ANEN]) begin
            ctl[`PBR_CTL_SPD0] <= an_speed100; // RULE5
            ctl[`PBR_CTL_DUP]  <= an_full; // RULE7
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign link_view = link_up_in && !ctl[`PBR_CTL_PWD]; // RULE8

   // a fault in the same cycle as the read survives it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rf <= 1'b0;
      end else if (srst_done) begin
         rf <= 1'b0; // RULE2 RULE19
      end else begin
         rf <= remote_fault_in | (rf & ~(rd_ev & rd_sel[1])); // RULE19
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link_ll <= 1'b0;
      end else if (srst_done) begin
         link_ll <= 1'b0; // RULE2
      end else if (rd_ev && rd_sel[1]) begin
         link_ll <= link_view; // RULE20
      end else if (!link_view) begin
         link_ll <= 1'b0; // RULE20
      end
   end

   always_comb begin
      sts                 = `PBR_STS_FIXED; // RULE12 RULE13 RULE14 RULE15 RULE21
      sts[`PBR_STS_ANC]   = autoneg_complete; // RULE18
      sts[`PBR_STS_RF]    = rf;
      sts[`PBR_STS_LINK]  = link_ll;
   end

   // unmapped addresses answer all zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 16'h0000;
      end else if (rd_ev) begin
         rd_data <= rd_sel[0] ? ctl : (rd_sel[1] ? sts : 16'h0000);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign core_reset      = ctl[`PBR_CTL_RST]; // RULE1
   assign loopback_en     = ctl[`PBR_CTL_LPBK]; // RULE3
   assign autoneg_enable  = ctl[`PBR_CTL_ANEN]; // RULE6
   assign autoneg_restart = ctl[`PBR_CTL_RSAN]; // RULE10
   assign power_down_bit  = ctl[`PBR_CTL_PWD]; // RULE8
   assign isolate         = ctl[`PBR_CTL_ISO]; // RULE9
   assign collision_test  = ctl[`PBR_CTL_COLT]; // RULE11

   // reserved speed codes fall back to 10 Mbps
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         speed_100   <= 1'b1;
         full_duplex <= 1'b1;
      end else begin
         speed_100   <= ctl[`PBR_CTL_ANEN] ? an_speed100 :
                        (!ctl[`PBR_CTL_SPD1] && ctl[`PBR_CTL_SPD0]); // RULE4
         full_duplex <= ctl[`PBR_CTL_ANEN] ? an_full : ctl[`PBR_CTL_DUP]; // RULE6
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // receive clock is passed straight, not gated by isolate or by the enable
   assign receive_clock_output = rx_clk_in;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_data_core           <= 4'h0;
         tx_ctl_core            <= 1'b0;
         rx_data_out            <= 4'h0;
         receive_control_output <= 1'b0;
         rx_oe                  <= 1'b0;
      end else begin
         tx_data_core           <= isolate ? 4'h0 : tx_data_in; // RULE9
         tx_ctl_core            <= isolate ? 1'b0 : transmit_control_input; // RULE9
         rx_data_out            <= rx_data_in;
         receive_control_output <= rx_ctl_in;
         rx_oe                  <= !isolate; // RULE9
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_srst_start;
      wr_ev && wr_sel[0] && eng_wr_data[`PBR_CTL_RST] && !core_reset
         |=> core_reset && srst_cnt == SRST_LOAD;
   endproperty
   a_srst_start: assert property (p_srst_start) else $error("soft reset not started"); // RULE1

   property p_srst_end;
      $fell(core_reset) |-> ctl == `PBR_CTL_DEF && !rf && !link_ll;
   endproperty
   a_srst_end: assert property (p_srst_end) else $error("defaults not restored"); // RULE2

   property p_loopback;
      wr_ev && wr_sel[0] && !core_reset && !srst_done
         |=> loopback_en == $past(eng_wr_data[`PBR_CTL_LPBK]);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback not written"); // RULE3

   property p_speed_forced;
      !autoneg_enable |=> speed_100 == ($past(ctl[`PBR_CTL_SPD0]) && !$past(ctl[`PBR_CTL_SPD1]));
   endproperty
   a_speed_forced: assert property (p_speed_forced) else $error("forced speed wrong"); // RULE4

   property p_an_result;
      an_rise && autoneg_enable && !srst_done
         |=> ctl[`PBR_CTL_SPD0] == $past(an_speed100) && ctl[`PBR_CTL_DUP] == $past(an_full);
   endproperty
   a_an_result: assert property (p_an_result) else $error("result not shown"); // RULE5 RULE7

   property p_duplex;
      !autoneg_enable ##1 !autoneg_enable |-> full_duplex == $past(ctl[`PBR_CTL_DUP]);
   endproperty
   a_duplex: assert property (p_duplex) else $error("forced duplex wrong"); // RULE6

   property p_pwd_link;
      power_down_bit && !(rd_ev && rd_sel[1]) |=> !link_ll;
   endproperty
   a_pwd_link: assert property (p_pwd_link) else $error("link up in power down"); // RULE8

   property p_isolate;
      isolate |=> !rx_oe && tx_ctl_core == 1'b0 && tx_data_core == 4'h0;
   endproperty
   a_isolate: assert property (p_isolate) else $error("isolate not applied"); // RULE9

   property p_restart;
      $rose(autoneg_restart) |=> !autoneg_restart;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not cleared"); // RULE10

   property p_status_fixed;
      (sts & 16'hF9C9) == `PBR_STS_FIXED && sts[`PBR_STS_ANC] == autoneg_complete;
   endproperty
   a_status_fixed: assert property (p_status_fixed) else $error("status bits wrong"); // RULE12

   property p_rf_clear;
      rd_ev && rd_sel[1] && !remote_fault_in |=> !rf;
   endproperty
   a_rf_clear: assert property (p_rf_clear) else $error("fault not cleared"); // RULE19

   property p_rf_set;
      remote_fault_in |=> rf || $past(srst_done);
   endproperty
   a_rf_set: assert property (p_rf_set) else $error("fault lost"); // RULE19

   property p_link_low;
      !link_view |=> !link_ll;
   endproperty
   a_link_low: assert property (p_link_low) else $error("link not latched low"); // RULE20

   property p_reserved;
      ctl[5:0] == 6'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set"); // RULE21

   property p_cv_srst;
      $fell(core_reset);
   endproperty
   c_cv_srst: cover property (p_cv_srst);

   property p_cv_rf;
      rf ##1 !rf;
   endproperty
   c_cv_rf: cover property (p_cv_rf);

   property p_cv_an;
      an_rise && autoneg_enable;
   endproperty
   c_cv_an: cover property (p_cv_an);

   property p_cv_write;
      wr_ev && wr_sel[0] ##1 isolate;
   endproperty
   c_cv_write: cover property (p_cv_write);
endmodule // pbr_regs

/* pbr_regs_tb.sv */
// self-checking bench for the basic register block
`include "pbr_cfg.svh"
module pbr_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SRST = 8;
   logic        clk, resetn, mdc, mdio_in, mdio_out, mdio_oe;
   logic        autoneg_complete, an_speed100, an_full, remote_fault_in, link_up_in;
   logic [3:0]  tx_data_in, tx_data_core, rx_data_in, rx_data_out;
   logic        transmit_control_input, tx_ctl_core, rx_clk_in, rx_ctl_in, rx_oe;
   logic        receive_clock_output, receive_control_output, core_reset, loopback_en;
   logic        speed_100, full_duplex, autoneg_enable, autoneg_restart;
   logic        power_down_bit, isolate, collision_test, s;
   logic [16:0] r;
   logic [15:0] mw [4];
   int          err_total, total_checks, rst_cyc, rsan_cyc, pre_n, n;

   pbr_regs #(.SRST_CYCLES(SRST)) uut (.clk, .resetn, .mdc, .mdio_in, .mdio_out, .mdio_oe,
      .autoneg_complete, .an_speed100, .an_full, .remote_fault_in, .link_up_in,
      .tx_data_in, .transmit_control_input, .tx_data_core, .tx_ctl_core, .rx_clk_in,
      .rx_ctl_in, .rx_data_in, .receive_clock_output, .receive_control_output,
      .rx_data_out, .rx_oe, .core_reset, .loopback_en, .speed_100, .full_duplex,
      .autoneg_enable, .autoneg_restart, .power_down_bit, .isolate, .collision_test);
   pbr_smi_host host (.mdc, .mdio_in, .mdio_out, .mdio_oe);

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (core_reset === 1'b1) rst_cyc++;
      if (autoneg_restart === 1'b1) rsan_cyc++;
   end
   //////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [4:0] ra);
      host.frame(`PBR_OP_RD, 5'h00, ra, 16'h0000, pre_n, r);
      pre_n = 1;
   endtask
   // turnaround bit driven low is checked with the word
   task automatic chk_rd(input logic [4:0] ra, input logic [15:0] e);
      rd(ra);
      check(r, {1'b0, e});
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      host.frame(`PBR_OP_WR, 5'h00, ra, d, pre_n, r);
      pre_n = 1;
      repeat (10) @(posedge clk);
   endtask
   initial begin
      #400000;
      err_total++;
      close_out();
   end
   //////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      {autoneg_complete, an_speed100, an_full, remote_fault_in} = 4'h6;
      {link_up_in, transmit_control_input, rx_clk_in, rx_ctl_in} = 4'hF;
      tx_data_in = 4'h5;
      rx_data_in = 4'hA;
      mw = '{16'h4000, 16'h0800, 16'h0400, 16'h0080};
      pre_n = 32;
      // reset spans two mdc edges for the management side
      repeat (2) host.bit_cyc(1'b0, 1'b1, s);
      @(posedge clk) resetn <= 1'b1;
      repeat (2) @(posedge clk);
      check(17'({autoneg_enable, loopback_en, power_down_bit, isolate, collision_test,
                 core_reset, speed_100, full_duplex}), 17'h83);
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED);
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED | 16'h0004);
      @(posedge clk) link_up_in <= 1'b0;
      @(posedge clk) link_up_in <= 1'b1;
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED);
      chk_rd(`PBR_REG_CTL, `PBR_CTL_DEF);
      @(posedge clk) remote_fault_in <= 1'b1;
      @(posedge clk) remote_fault_in <= 1'b0;
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED | 16'h0014);
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED | 16'h0004);
      // refused frames and read-only places
      chk_rd(5'h02, 16'h0000);
      host.frame(`PBR_OP_RD, 5'h03, `PBR_REG_CTL, 16'h0000, 1, r);
      check(r, 17'h1FFFF);
      wr(`PBR_REG_STS, 16'h0000);
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED | 16'h0004);
      // speed codes; 10 and 11 behave as 10 Mbps
      for (int k = 0; k < 4; k++) begin
         wr(`PBR_REG_CTL, {2'b00, k[0], 6'h00, k[1], 6'h3F});
         check(17'(speed_100), 17'(k == 1));
         check(17'(full_duplex), 17'h0);
         chk_rd(`PBR_REG_CTL, {2'b00, k[0], 6'h00, k[1], 6'h00});
      end
      check(17'({rx_oe, tx_data_core, tx_ctl_core, rx_data_out, receive_control_output,
                 receive_clock_output}), 17'h0AEB);
      for (int k = 0; k < 4; k++) begin
         wr(`PBR_REG_CTL, mw[k] | 16'h0100);
         check(17'({loopback_en, power_down_bit, isolate, collision_test}),
               17'(4'b1000 >> k));
         check(17'(full_duplex), 17'h1);
         if (k == 1) chk_rd(`PBR_REG_STS, `PBR_STS_FIXED);
         if (k == 2) check(17'({rx_oe, tx_data_core, tx_ctl_core}), 17'h0);
      end
      rsan_cyc = 0;
      wr(`PBR_REG_CTL, 16'h1200);
      check(17'(rsan_cyc), 17'h1);
      chk_rd(`PBR_REG_CTL, 16'h1000);
      // negotiation outcome rewrites speed and duplex bits
      for (int k = 1; k >= 0; k--) begin
         @(posedge clk) begin
            an_speed100 <= k[0];
            an_full <= k[0];
            autoneg_complete <= 1'b0;
         end
         @(posedge clk) autoneg_complete <= 1'b1;
         repeat (4) @(posedge clk);
         chk_rd(`PBR_REG_CTL, 16'h1000 | {2'b00, k[0], 4'h0, k[0], 8'h00});
         check(17'({speed_100, full_duplex}), 17'({k[0], k[0]}));
      end
      rd(`PBR_REG_STS);
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED | 16'h0024);
      // software reset with a fault pending and loopback on
      @(posedge clk) remote_fault_in <= 1'b1;
      @(posedge clk) remote_fault_in <= 1'b0;
      rst_cyc = 0;
      wr(`PBR_REG_CTL, 16'hC000);
      for (n = 0; n < 100 && core_reset !== 1'b0; n++) @(posedge clk);
      if (n == 100) begin
         err_total++;
         close_out();
      end
      check(17'(rst_cyc), 17'(SRST));
      check(17'({loopback_en, autoneg_enable}), 17'h1);
      chk_rd(`PBR_REG_CTL, `PBR_CTL_DEF);
      chk_rd(`PBR_REG_STS, `PBR_STS_FIXED | 16'h0020);
      close_out();
   end
endmodule // pbr_regs_tb

/* pbr_smi_host.sv */
// station management host model driving mdc and mdio frames
module pbr_smi_host (
   output logic      mdc,
   output logic      mdio_in,
   input  wire logic mdio_out,
   input  wire logic mdio_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic host_oe = 1'b0;
   logic host_d  = 1'b1;
   // pull-up on the wire; both driving shows as unknown
   assign mdio_in = (mdio_oe & host_oe) ? 1'bx : mdio_oe ? mdio_out : host_oe ? host_d : 1'b1;
   // mdc stands low outside frames
   initial mdc = 1'b0;
   //////////////////////////////////////////////////////////////
   task automatic bit_cyc(input logic oe, input logic d, output logic s);
      host_oe = oe;
      host_d  = d;
      // odd offset keeps rising mdc edges off the clk edges
      #41.3;
      s   = mdio_in;
      mdc = 1'b1;
      #38.7;
      mdc = 1'b0;
   endtask
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, input int pre, output logic [16:0] rd);
      logic [31:0] hdr;
      logic        s;
      hdr = {2'b01, op, pa, ra, 2'b10, wd};
      rd  = '0;
      // preamble also serves as the idle bit between frames
      repeat (pre) bit_cyc(1'b1, 1'b1, s);
      for (int i = 31; i >= 0; i--) begin
         bit_cyc(op == 2'h1 || i > 17, hdr[i], s);
         if (i <= 16) rd = {rd[15:0], s};
      end
      // one released bit lets the device drop its drive
      bit_cyc(1'b0, 1'b1, s);
   endtask
endmodule // pbr_smi_host
